// file: ivpl_consts.vh
// Purpose: Constants for the interrupt vector, priority and low-voltage block
// Assumes: 32-bit Avalon-MM register words, byte addresses multiple of four
// Notes: Vector table sits at the top of the 16-bit address space
//
// Contract
// - Each vector is two bytes, routine high address byte first, low byte at the next address.
// - Priority rises as vector number falls, 31 lowest and 0 highest.
// - A source flag sets on its condition and requests only while its local enable is 1.
// - With the global mask clear the core finishes, stacks PC low, PC high, X, A, CONDITION_CODE_REG, masks, fetches.
// - Vector n starts at 0xfffe minus twice n; unused vectors carry no source.
// - Watchdog, low-voltage reset, reset pin, illegal opcode and illegal address go to vector 0.
// - The low-voltage detector is active only while its enable bit is 1.
// - Stop entry turns the detector off unless its stop-enable bit is set.
// - With enable and stop-enable both set, deep stop is refused and shallow stop keeps it running.
// - Power-on reset sets both the power-on and low-voltage reset status flags.
// - With reset-enable at 1 a detected low voltage makes a system reset; the select picks the trip.
// - After a low-voltage or power-on reset the system is held in reset until supply is above trip.
// - The low-voltage status flag is set after a low-voltage reset and after power-on reset.
// - A warning with its interrupt enable at 1 sets the warning flag and requests vector 3.
// - With several requests pending the highest-priority source is serviced first.
`ifndef IVPL_CONSTS_VH
`define IVPL_CONSTS_VH

`define IVPL_NUM_VEC 32
`define IVPL_VEC_TOP 16'hfffe
`define IVPL_VEC_RESET 5'h00
`define IVPL_VEC_SWI 5'h01
`define IVPL_VEC_WARN 5'h03

// Register byte offsets
`define IVPL_OFS_PMC1 6'h00
`define IVPL_OFS_RSTAT 6'h04
`define IVPL_OFS_SRCFLAG 6'h08
`define IVPL_OFS_SRCEN 6'h0c
`define IVPL_OFS_SRCCLR 6'h10
`define IVPL_OFS_VEC 6'h14
`define IVPL_OFS_IRQSTAT 6'h18
`define IVPL_OFS_IRQEN 6'h1c
`define IVPL_OFS_IRQCLR 6'h20

// Power management control fields
`define IVPL_PMC_WFLAG 7
`define IVPL_PMC_WACK 6
`define IVPL_PMC_WIE 5
`define IVPL_PMC_DSE 4
`define IVPL_PMC_DRE 3
`define IVPL_PMC_DEN 2
`define IVPL_PMC_VSEL 0
`define IVPL_PMC_RESET 8'h1c

// Reset status fields
`define IVPL_RS_POR 7
`define IVPL_RS_PIN 6
`define IVPL_RS_WDOG 5
`define IVPL_RS_ILOP 4
`define IVPL_RS_ILAD 3
`define IVPL_RS_LV 1

// Block interrupt status bits
`define IVPL_EV_WARN 0
`define IVPL_EV_LVRST 1
`define IVPL_EV_STOPREF 2
`define IVPL_EV_W 3

// Hold-off after supply good before reset release
`define IVPL_HOLD_NS 100
`define IVPL_CLK_NS 10

`endif

// file: ivpl_prio_enc.v
// Purpose: Combinational priority encoder over masked pending requests
// Assumes: Bit 0 is the highest priority
// Notes: Purely combinational so the vector tracks requests without latency
`timescale 1ns/1ps
module ivpl_prio_enc #(
  parameter N = 32,
  parameter W = 5
) (
  // Requests
  input wire [N-1:0] req,
  // Result
  output reg any,
  output reg [W-1:0] vec
);
  integer i;
  always @* begin
    any = 1'b0;
    vec = {W{1'b0}};
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (req[i]) begin
        any = 1'b1;
        vec = i[W-1:0];
      end
    end
  end
endmodule

// file: ivpl_sync3.v
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input is asynchronous to core_clk
// Notes: Output changes only when stages two and three agree
`timescale 1ns/1ps
module ivpl_sync3 #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // Clocking
  input wire core_clk,
  input wire rst_n,
  input wire clk_en,
  // Data
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  reg [W-1:0] s3_ff;
  genvar g;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= INIT;
      s2_ff <= INIT;
      s3_ff <= INIT;
    end else if (clk_en) begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          dout[g] <= INIT[g];
        end else if (clk_en && (s2_ff[g] == s3_ff[g])) begin
          dout[g] <= s3_ff[g];
        end
      end
    end
  endgenerate
endmodule

// file: ivpl_top.v
// Purpose: Interrupt vector selection, reset merge and low-voltage detect control
// Assumes: Core handles stacking; analog detector supplies raw compare levels
// Notes: Registers on Avalon-MM, one word each, upper bits read zero
//
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "ivpl_consts.vh"
module ivpl_top #(
  parameter HOLD_CYC = (`IVPL_HOLD_NS + `IVPL_CLK_NS - 1) / `IVPL_CLK_NS
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  input wire clk_en,
  // Avalon-MM slave
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Peripheral source flag pulses, vector index order
  input wire [31:0] src_set,
  // Core vector fetch
  input wire core_global_mask,
  input wire core_vec_ack,
  input wire swi_exec,
  output reg core_irq,
  output reg [4:0] core_vec_num,
  output reg [15:0] core_vec_addr,
  // Reset sources, pin and power-on asynchronous
  input wire por_event_n,
  input wire reset_pin_n,
  input wire wdog_timeout,
  input wire illegal_opcode,
  input wire illegal_addr,
  // Analog detector, asynchronous
  input wire lv_detect_raw,
  input wire lv_warn_raw,
  // Stop requests
  input wire stop_req,
  input wire stop_deep,
  // Power control outputs
  output reg detector_on,
  output reg detector_voltage_select,
  output reg system_reset,
  output reg deep_stop_mode,
  output reg shallow_stop_mode,
  output reg irq
);
  localparam [2:0] S_RUN = 3'b001;
  localparam [2:0] S_HOLD = 3'b010;
  localparam [2:0] S_STOP = 3'b100;
  localparam [7:0] HOLD_W = HOLD_CYC;

  wire lv_det;
  wire lv_warn;
  wire pin_n;
  wire por_n;
  wire enc_any;
  wire [4:0] enc_vec;
  wire [31:0] pending;
  wire wr_hit;
  wire rd_hit;
  wire [3:0] wr_idx;
  wire [3:0] ev_set;
  wire rst_cause;

  reg [7:0] pmc_ff;
  reg [7:0] rstat_ff;
  reg [31:0] flag_ff;
  reg [31:0] en_ff;
  reg [3:0] ev_ff;
  reg [3:0] ev_en_ff;
  reg [2:0] state_ff;
  reg [7:0] hold_ff;
  reg por_seen_ff;
  reg [31:0] nxt_flag;
  reg [31:0] nxt_rdata;
  reg [2:0] nxt_state;

  // Detector starts out reporting low supply, so reset holds until it settles
  ivpl_sync3 #(.W(4), .INIT(4'b1011)) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .din({lv_detect_raw, lv_warn_raw, reset_pin_n, por_event_n}),
    .dout({lv_det, lv_warn, pin_n, por_n})
  );

  // level requests; vector 3 is enabled by the warning enable
  assign pending = flag_ff & {en_ff[31:4], pmc_ff[`IVPL_PMC_WIE], en_ff[2:0]};

  ivpl_prio_enc #(.N(`IVPL_NUM_VEC), .W(5)) u_enc (
    .req(pending),
    .any(enc_any),
    .vec(enc_vec)
  );

  assign wr_hit = avs_write && !avs_waitrequest;
  assign rd_hit = avs_read && !avs_waitrequest;
  assign wr_idx = avs_address[5:2];

  // detector qualifies its inputs only while enabled
  wire det_active = pmc_ff[`IVPL_PMC_DEN] && (state_ff != S_STOP || detector_on);
  // low voltage resets only with reset-enable set
  wire lv_reset = det_active && lv_det && pmc_ff[`IVPL_PMC_DRE];
  // low-voltage, pin, watchdog, illegal opcode and illegal address resets merge onto vector 0; por_event_n does not
  assign rst_cause = lv_reset || !pin_n || wdog_timeout || illegal_opcode || illegal_addr;
  wire warn_hit = det_active && lv_warn && pmc_ff[`IVPL_PMC_WIE];
  wire stop_refused = stop_req && stop_deep && pmc_ff[`IVPL_PMC_DEN] && pmc_ff[`IVPL_PMC_DSE];
  assign ev_set = {1'b0, stop_refused && state_ff == S_RUN, lv_reset, warn_hit};

  // Source flags: set wins over clear
  always @* begin
    nxt_flag = flag_ff;
    if (wr_hit && wr_idx == (`IVPL_OFS_SRCCLR >> 2)) begin
      nxt_flag = nxt_flag & ~avs_writedata;
    end
    if (core_vec_ack && enc_any && enc_vec != `IVPL_VEC_RESET && enc_vec != `IVPL_VEC_WARN) begin
      nxt_flag[enc_vec] = 1'b0;
    end
    nxt_flag = nxt_flag | src_set;
    nxt_flag[`IVPL_VEC_SWI] = nxt_flag[`IVPL_VEC_SWI] | swi_exec;
    nxt_flag[`IVPL_VEC_WARN] = pmc_ff[`IVPL_PMC_WFLAG];
    nxt_flag[`IVPL_VEC_RESET] = 1'b0;
    nxt_flag[31] = 1'b0;
    nxt_flag[29:27] = 3'h0;
    nxt_flag[22] = 1'b0;
    nxt_flag[19] = 1'b0;
    nxt_flag[10:7] = 4'h0;
    nxt_flag[4] = 1'b0;
  end

  // Reset and stop sequencing
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      S_RUN: begin
        if (rst_cause) begin
          nxt_state = S_HOLD;
        end else if (stop_req && !stop_refused) begin
          nxt_state = S_STOP;
        end
      end
      S_HOLD: begin
        // release only once supply is above trip
        if (!rst_cause && !(pmc_ff[`IVPL_PMC_DEN] && lv_det) && hold_ff == 8'h00) begin
          nxt_state = S_RUN;
        end
      end
      S_STOP: begin
        if (!stop_req) begin
          nxt_state = S_RUN;
        end else if (rst_cause) begin
          nxt_state = S_HOLD;
        end
      end
      default: nxt_state = S_HOLD;
    endcase
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= S_HOLD;
      hold_ff <= HOLD_W;
      por_seen_ff <= 1'b0;
      pmc_ff <= `IVPL_PMC_RESET;
      rstat_ff <= 8'h00;
      flag_ff <= 32'h0;
      en_ff <= 32'h0;
      ev_ff <= 4'h0;
      ev_en_ff <= 4'h0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      flag_ff <= nxt_flag;
      if (state_ff == S_HOLD && !lv_det) begin
        hold_ff <= (hold_ff == 8'h00) ? 8'h00 : hold_ff - 8'h01;
      end else if (state_ff == S_HOLD) begin
        hold_ff <= HOLD_W;
      end
      if (state_ff != S_HOLD && nxt_state == S_HOLD) begin
        hold_ff <= HOLD_W;
      end
      // power-on sets power-on and low-voltage flags
      if (!por_n || !por_seen_ff) begin
        por_seen_ff <= 1'b1;
        rstat_ff <= 8'h00;
        rstat_ff[`IVPL_RS_POR] <= 1'b1;
        rstat_ff[`IVPL_RS_LV] <= 1'b1;
        pmc_ff <= `IVPL_PMC_RESET;
      end else if (state_ff != S_HOLD && nxt_state == S_HOLD) begin
        rstat_ff[`IVPL_RS_POR] <= 1'b0;
        rstat_ff[`IVPL_RS_LV] <= lv_reset;
        rstat_ff[`IVPL_RS_PIN] <= !pin_n;
        rstat_ff[`IVPL_RS_WDOG] <= wdog_timeout;
        rstat_ff[`IVPL_RS_ILOP] <= illegal_opcode;
        rstat_ff[`IVPL_RS_ILAD] <= illegal_addr;
        pmc_ff <= `IVPL_PMC_RESET;
        en_ff <= 32'h0;
      end else begin
        if (wr_hit && wr_idx == (`IVPL_OFS_PMC1 >> 2)) begin
          pmc_ff[5:0] <= {avs_writedata[5:2], 1'b0, avs_writedata[0]};
        end
        if (warn_hit) begin
          pmc_ff[`IVPL_PMC_WFLAG] <= 1'b1;
        end else if (wr_hit && wr_idx == (`IVPL_OFS_PMC1 >> 2) && avs_writedata[`IVPL_PMC_WACK]) begin
          pmc_ff[`IVPL_PMC_WFLAG] <= 1'b0;
        end
        if (wr_hit && wr_idx == (`IVPL_OFS_SRCEN >> 2)) begin
          en_ff <= avs_writedata;
        end
      end
      if (wr_hit && wr_idx == (`IVPL_OFS_IRQEN >> 2)) begin
        ev_en_ff <= avs_writedata[3:0];
      end
      if (wr_hit && wr_idx == (`IVPL_OFS_IRQCLR >> 2)) begin
        ev_ff <= (ev_ff & ~avs_writedata[3:0]) | ev_set;
      end else begin
        ev_ff <= ev_ff | ev_set;
      end
    end
  end

  // Read mux
  always @* begin
    nxt_rdata = 32'h0;
    case (wr_idx)
      (`IVPL_OFS_PMC1 >> 2): nxt_rdata = {24'h0, pmc_ff};
      (`IVPL_OFS_RSTAT >> 2): nxt_rdata = {24'h0, rstat_ff};
      (`IVPL_OFS_SRCFLAG >> 2): nxt_rdata = flag_ff;
      (`IVPL_OFS_SRCEN >> 2): nxt_rdata = en_ff;
      (`IVPL_OFS_VEC >> 2): nxt_rdata = {15'h0, enc_any, 11'h0, enc_vec};
      (`IVPL_OFS_IRQSTAT >> 2): nxt_rdata = {28'h0, ev_ff};
      (`IVPL_OFS_IRQEN >> 2): nxt_rdata = {28'h0, ev_en_ff};
      default: nxt_rdata = 32'h0;
    endcase
  end

  // Bus answers one cycle after the request, waitrequest high otherwise
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else if (clk_en) begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (rd_hit) begin
        avs_readdata <= 32'h0;
      end else if (avs_read && avs_waitrequest) begin
        avs_readdata <= nxt_rdata;
      end
    end
  end

  // Core facing outputs, registered
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_irq <= 1'b0;
      core_vec_num <= `IVPL_VEC_RESET;
      core_vec_addr <= `IVPL_VEC_TOP;
      detector_on <= 1'b0;
      detector_voltage_select <= 1'b0;
      system_reset <= 1'b1;
      deep_stop_mode <= 1'b0;
      shallow_stop_mode <= 1'b0;
      irq <= 1'b0;
    end else if (clk_en) begin
      // core takes request only with its global mask clear
      core_irq <= enc_any && !core_global_mask && nxt_state != S_HOLD;
      // reset forces vector 0; the fetch reads the vector one cycle on
      core_vec_num <= (nxt_state == S_HOLD) ? `IVPL_VEC_RESET : enc_vec;
      // entry n begins at top minus 2n, high byte first
      core_vec_addr <= `IVPL_VEC_TOP - {10'h0, ((nxt_state == S_HOLD) ? 5'h00 : enc_vec), 1'b0};
      // stop turns detector off unless stop-enable set
      detector_on <= pmc_ff[`IVPL_PMC_DEN] && (nxt_state != S_STOP || pmc_ff[`IVPL_PMC_DSE]);
      detector_voltage_select <= pmc_ff[`IVPL_PMC_VSEL];
      system_reset <= nxt_state == S_HOLD;
      // deep stop refused while detector stays on in stop
      deep_stop_mode <= nxt_state == S_STOP && stop_deep && !stop_refused;
      shallow_stop_mode <= nxt_state == S_STOP && !(stop_deep && !stop_refused);
      irq <= |(ev_ff & ev_en_ff);
    end
  end
endmodule

// file: ivpl_top_monitor.sv
// Purpose: Port checker for ivpl_top
// Assumes: Power control resets to 0x1c
// Notes: Mirrors accepted power control writes to know the enables
`timescale 1ns/1ps
module ivpl_top_monitor (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Inputs watched, plus the avs_waitrequest output
  input wire [5:0] avs_address,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire avs_waitrequest,
  input wire [31:0] src_set,
  input wire swi_exec,
  input wire core_vec_ack,
  input wire reset_pin_n,
  input wire wdog_timeout,
  input wire illegal_opcode,
  input wire illegal_addr,
  input wire lv_detect_raw,
  input wire lv_warn_raw,
  // Outputs watched
  input wire core_irq,
  input wire [4:0] core_vec_num,
  input wire [15:0] core_vec_addr,
  input wire detector_on,
  input wire system_reset,
  input wire deep_stop_mode,
  input wire shallow_stop_mode
);
  reg den_ff;
  reg dre_ff;
  reg dse_ff;
  // Nothing that could move the pending set this cycle
  wire quiet = src_set == 32'h0 && !swi_exec && !avs_write && !core_vec_ack && !lv_warn_raw &&
    !system_reset;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      den_ff <= 1'b1;
      dre_ff <= 1'b1;
      dse_ff <= 1'b1;
    end else if (avs_write && !avs_waitrequest && avs_address == 6'h00 && !system_reset) begin
      den_ff <= avs_writedata[2];
      dre_ff <= avs_writedata[3];
      dse_ff <= avs_writedata[4];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_vec_addr_map: assert property (core_irq && !system_reset && !$past(system_reset) |->
    core_vec_addr == 16'hfffe - {10'h0, core_vec_num, 1'b0}) else $error("bad vector address");
  a_held_reset_vec: assert property (system_reset && $past(system_reset) |->
    core_vec_addr == 16'hfffe) else $error("reset vector not driven");
  a_fault_reset: assert property (wdog_timeout || illegal_opcode || illegal_addr |->
    ##[1:4] system_reset) else $error("fault gave no reset");
  a_pin_reset: assert property ($fell(reset_pin_n) |-> ##[1:8] system_reset)
    else $error("pin gave no reset");
  a_det_off: assert property (!den_ff && !$past(den_ff, 2) |-> !detector_on)
    else $error("detector on while disabled");
  a_stop_det_off: assert property (shallow_stop_mode && $past(shallow_stop_mode) &&
    !dse_ff && !$past(dse_ff) |-> !detector_on) else $error("detector on in stop");
  a_deep_refused: assert property (deep_stop_mode |-> !(den_ff && dse_ff))
    else $error("deep stop with detector kept");
  a_lv_reset: assert property (lv_detect_raw && den_ff && dre_ff |-> ##[1:8] system_reset)
    else $error("low voltage gave no reset");
  a_lv_hold: assert property ($fell(system_reset) |-> !$past(lv_detect_raw, 3))
    else $error("reset released in low voltage");
  a_vec_stable: assert property (quiet [*3] ##0 core_irq |=> $stable(core_vec_num))
    else $error("vector moved without cause");
  cover property (core_vec_ack && core_vec_num != 5'h00);
  cover property (shallow_stop_mode && !detector_on);
  cover property (core_irq && core_vec_num == 5'h03);
endmodule
bind ivpl_top ivpl_top_monitor u_mon (.core_clk(core_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest), .src_set(src_set), .swi_exec(swi_exec),
  .core_vec_ack(core_vec_ack), .reset_pin_n(reset_pin_n), .wdog_timeout(wdog_timeout),
  .illegal_opcode(illegal_opcode), .illegal_addr(illegal_addr), .lv_detect_raw(lv_detect_raw),
  .lv_warn_raw(lv_warn_raw), .core_irq(core_irq), .core_vec_num(core_vec_num),
  .core_vec_addr(core_vec_addr), .detector_on(detector_on), .system_reset(system_reset),
  .deep_stop_mode(deep_stop_mode), .shallow_stop_mode(shallow_stop_mode));

// file: ivpl_core_model.sv
// Purpose: Behavioural core that takes interrupts and fetches vectors
// Assumes: Vector number is valid while core_irq is high
// Notes: gap stretches each service routine, so spacing varies
`timescale 1ns/1ps
module ivpl_core_model (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Bench controls
  input wire hold_mask,
  input wire [3:0] gap,
  // Core side
  input wire core_irq,
  input wire [4:0] core_vec_num,
  output wire core_global_mask,
  output reg core_vec_ack
);
  integer busy;
  logic [4:0] served[$];
  // Mask stays set for the whole routine so nothing nests
  assign core_global_mask = hold_mask || busy != 0;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 0;
      core_vec_ack <= 1'b0;
    end else begin
      core_vec_ack <= 1'b0;
      // stack PC low, PC high, X, A, CONDITION_CODE_REG, mask, fetch top vector
      if (busy == 0 && core_irq === 1'b1 && !hold_mask) begin
        served.push_back(core_vec_num);
        core_vec_ack <= 1'b1;
        busy <= gap + 4;
      end else if (busy != 0) begin
        busy <= busy - 1;
      end
    end
  end
endmodule

// file: tb_top.sv
// Purpose: Self-checking bench for ivpl_top
// Assumes: Flags and enables mirrored in integers
// Notes: HOLD_CYC cut to 2 so resets release quickly
`timescale 1ns/1ps
module tb_top;
  localparam logic [31:0] VALID = 32'h47b7f866;
  logic core_clk, rst_n, avs_read, avs_write, swi_exec, reset_pin_n, wdog_timeout;
  logic illegal_opcode, illegal_addr, lv_detect_raw, lv_warn_raw, stop_req, stop_deep;
  logic hold_mask, core_global_mask, core_vec_ack, core_irq, avs_waitrequest, irq, por_event_n;
  logic detector_on, detector_voltage_select, system_reset, deep_stop_mode, shallow_stop_mode;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, src_set, q, s;
  logic [4:0] core_vec_num;
  logic [15:0] core_vec_addr;
  logic [3:0] gap;
  integer n_mismatch = 0, num_checks = 0, mflag, men, i, k;
  integer exp_q[$];
  ivpl_top #(.HOLD_CYC(2)) dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .src_set(src_set), .core_global_mask(core_global_mask), .core_vec_ack(core_vec_ack),
    .swi_exec(swi_exec), .core_irq(core_irq), .core_vec_num(core_vec_num),
    .core_vec_addr(core_vec_addr), .por_event_n(por_event_n), .reset_pin_n(reset_pin_n),
    .wdog_timeout(wdog_timeout), .illegal_opcode(illegal_opcode), .illegal_addr(illegal_addr),
    .lv_detect_raw(lv_detect_raw), .lv_warn_raw(lv_warn_raw), .stop_req(stop_req),
    .stop_deep(stop_deep), .detector_on(detector_on), .detector_voltage_select(detector_voltage_select),
    .system_reset(system_reset), .deep_stop_mode(deep_stop_mode),
    .shallow_stop_mode(shallow_stop_mode), .irq(irq));
  ivpl_core_model core (.core_clk(core_clk), .rst_n(rst_n), .hold_mask(hold_mask), .gap(gap),
    .core_irq(core_irq), .core_vec_num(core_vec_num), .core_global_mask(core_global_mask),
    .core_vec_ack(core_vec_ack));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    integer t;
    begin
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      t = 0;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0 && t < 50) begin
        @(posedge core_clk);
        t = t + 1;
      end
      if (t >= 50) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch at %0t: bus answer timed out", $time);
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task wait_sr(input logic v);
    integer t;
    begin
      for (t = 0; t < 100 && system_reset !== v; t = t + 1) @(posedge core_clk);
      chk(32'(system_reset), 32'(v));
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    #300000;
    n_mismatch = n_mismatch + 1;
    complete_run;
  end
  initial begin
    {avs_read, avs_write, swi_exec, wdog_timeout, illegal_opcode, illegal_addr} = 6'h0;
    {lv_warn_raw, stop_req, stop_deep, rst_n} = 4'h0;
    {reset_pin_n, lv_detect_raw, hold_mask, por_event_n} = 4'hf;
    avs_address = 6'h0;
    avs_writedata = 32'h0;
    src_set = 32'h0;
    gap = 4'h0;
    mflag = 0;
    k = $urandom(32'h64077f34);
    repeat (10) @(posedge core_clk);
    chk(32'(core_vec_addr), 32'hfffe);
    rst_n <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk(32'(system_reset), 32'h1);
    lv_detect_raw <= 1'b0;
    wait_sr(1'b0);
    bus(1'b0, 6'h04, 32'h0);
    chk(q, 32'h82);
    bus(1'b0, 6'h00, 32'h0);
    chk(q, 32'h1c);
    bus(1'b0, 6'h3c, 32'h0);
    chk(q, 32'h0);
    for (i = 0; i < 8; i = i + 1) begin
      men = ($urandom & VALID) | 2;
      bus(1'b1, 6'h0c, men);
      s = $urandom & VALID;
      src_set <= s;
      swi_exec <= i[0];
      @(posedge core_clk);
      src_set <= 32'h0;
      swi_exec <= 1'b0;
      mflag = mflag | s | (i[0] ? 2 : 0);
      bus(1'b0, 6'h08, 32'h0);
      chk(q, mflag);
      for (k = 0; k < 32 && ((mflag & men) >> k) % 2 == 0; k = k + 1);
      bus(1'b0, 6'h14, 32'h0);
      chk(q, (k < 32) ? 32'h10000 + k : 32'h0);
      if (k < 32)
        chk(32'(core_vec_addr), 32'hfffe - 2 * k);
      s = $urandom & VALID;
      bus(1'b1, 6'h10, s);
      mflag = mflag & ~s;
    end
    bus(1'b1, 6'h0c, VALID);
    s = $urandom & VALID;
    src_set <= s;
    @(posedge core_clk);
    src_set <= 32'h0;
    mflag = mflag | s;
    for (k = 0; k < 32; k = k + 1)
      if (mflag >> k & 1)
        exp_q.push_back(k);
    gap <= $urandom;
    hold_mask <= 1'b0;
    for (i = 0; i < 2000 && core.served.size() < exp_q.size(); i = i + 1) @(posedge core_clk);
    hold_mask <= 1'b1;
    chk(core.served.size(), exp_q.size());
    for (i = 0; i < exp_q.size(); i = i + 1)
      chk(32'(core.served[i]), exp_q[i]);
    for (i = 0; i < 4; i = i + 1) begin
      {wdog_timeout, illegal_opcode, illegal_addr} <= 3'b100 >> i;
      reset_pin_n <= (i != 3);
      @(posedge core_clk);
      {wdog_timeout, illegal_opcode, illegal_addr} <= 3'h0;
      wait_sr(1'b1);
      @(posedge core_clk);
      chk(32'(core_vec_addr), 32'hfffe);
      reset_pin_n <= 1'b1;
      wait_sr(1'b0);
      bus(1'b0, 6'h04, 32'h0);
      chk(q >> (5 - i + (i == 3) * 4) & 1, 32'h1);
    end
    lv_detect_raw <= 1'b1;
    wait_sr(1'b1);
    repeat (20) @(posedge core_clk);
    chk(32'(system_reset), 32'h1);
    lv_detect_raw <= 1'b0;
    wait_sr(1'b0);
    bus(1'b0, 6'h04, 32'h0);
    chk(q, 32'h2);
    bus(1'b1, 6'h00, 32'h19);
    repeat (2) @(posedge core_clk);
    chk(32'({detector_on, detector_voltage_select}), 32'h1);
    lv_detect_raw <= 1'b1;
    repeat (12) @(posedge core_clk);
    chk(32'(system_reset), 32'h0);
    lv_detect_raw <= 1'b0;
    repeat (8) @(posedge core_clk);
    bus(1'b1, 6'h00, 32'h1c);
    {stop_req, stop_deep} <= 2'b11;
    repeat (4) @(posedge core_clk);
    chk(32'({deep_stop_mode, detector_on}), 32'h1);
    {stop_req, stop_deep} <= 2'b00;
    bus(1'b0, 6'h18, 32'h0);
    chk(q & 4, 32'h4);
    bus(1'b1, 6'h00, 32'h0c);
    stop_req <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(32'({shallow_stop_mode, detector_on}), 32'h2);
    stop_deep <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(32'({deep_stop_mode, shallow_stop_mode, detector_on}), 32'h4);
    {stop_req, stop_deep} <= 2'b00;
    bus(1'b1, 6'h20, 32'h7);
    bus(1'b1, 6'h00, 32'h3c);
    bus(1'b1, 6'h1c, 32'h1);
    lv_warn_raw <= 1'b1;
    repeat (8) @(posedge core_clk);
    lv_warn_raw <= 1'b0;
    repeat (4) @(posedge core_clk);
    bus(1'b0, 6'h00, 32'h0);
    chk(q & 32'h80, 32'h80);
    bus(1'b0, 6'h14, 32'h0);
    chk(q, 32'h10003);
    chk(32'(irq), 32'h1);
    bus(1'b1, 6'h1c, 32'h0);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h0);
    bus(1'b1, 6'h00, 32'h7c);
    bus(1'b1, 6'h20, 32'h1);
    bus(1'b1, 6'h1c, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h0);
    bus(1'b0, 6'h14, 32'h0);
    chk(q, 32'h0);
    por_event_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    por_event_n <= 1'b1;
    bus(1'b0, 6'h04, 32'h0);
    chk(q, 32'h82);
    complete_run;
  end
endmodule
